// ---- hdl/fr_timer_defines.svh ----
`ifndef FR_TIMER_DEFINES_SVH
`define FR_TIMER_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define ADDR_MODE 5'h00
`define ADDR_CAP 5'h04
`define ADDR_OUTC 5'h08
`define ADDR_CNT 5'h0c
`define ADDR_CC_A 5'h10
`define ADDR_CC_B 5'h14

// ==========================================================
// Field positions
`define MODE_HI_BIT 1
`define MODE_LO_BIT 0
`define OVF_BIT 2
`define OUT_EN_BIT 0
`define OS_EN_BIT 1
`define OS_TRIG_BIT 2
`define OS_BUSY_BIT 3
`define TOUT_BIT 4
`define EDGE_RISE_BIT 0
`define EDGE_FALL_BIT 1
`define LANE0 0
`define LANE1 1

// ==========================================================
// Values
`define CNT_ZERO 16'h0000
`define CNT_MAX 16'hffff
`define CNT_ONE 16'h0001
`define DATA_ZERO 32'h0000_0000
`define HALF_ZERO 16'h0000

`endif

// ---- hdl/fr_timer_pkg.sv ----
package fr_timer_pkg;

  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_FREE = 2'b01,
    MODE_EDGE_CLR = 2'b10,
    MODE_MATCH_CLR = 2'b11
  } mode_e;

  typedef enum logic {
    OS_IDLE = 1'b0,
    OS_BUSY = 1'b1
  } os_state_e;

  typedef struct packed {
    logic [1:0] edge_b;
    logic [1:0] edge_a;
    logic a_src_in_a;
    logic b_is_cap;
    logic a_is_cap;
  } cap_ctrl_s;

  typedef struct packed {
    logic oneshot_enable;
    logic out_enable;
  } out_ctrl_s;

  typedef struct packed {
    logic event_b;
    logic event_a;
  } evt_s;

endpackage

// ---- hdl/free_run_ppg_oneshot_timer.sv ----
`include "fr_timer_defines.svh"

module free_run_ppg_oneshot_timer (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_timer_in_a,
  input wire logic i_timer_in_b,
  output logic o_timer_out,
  output logic o_event_a,
  output logic o_event_b
);

  // ==========================================================
  // Helpers
  function automatic logic edge_hit(
    input logic cur,
    input logic prev,
    input logic [1:0] sel
  );
    edge_hit = (sel[`EDGE_RISE_BIT] & cur & ~prev)
             | (sel[`EDGE_FALL_BIT] & ~cur & prev);
  endfunction

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] be
  );
    merge16 = old;
    if (be[`LANE0]) begin
      merge16[7:0] = data[7:0];
    end
    if (be[`LANE1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {`HALF_ZERO, v};
  endfunction

  function automatic logic cnt_hits(
    input logic [15:0] cnt,
    input logic [15:0] ref_val
  );
    cnt_hits = cnt == ref_val;
  endfunction

  function automatic logic [15:0] cc_next(
    input logic [15:0] old,
    input logic [15:0] cnt,
    input logic cap,
    input logic wr,
    input logic [31:0] data,
    input logic [3:0] be
  );
    cc_next = old;
    if (wr) begin
      cc_next = merge16(old, data, be);
    end
    // Capture wins over a same-cycle write
    if (cap) begin
      cc_next = cnt;
    end
  endfunction

  // ==========================================================
  // State
  fr_timer_pkg::mode_e mode_r;
  fr_timer_pkg::mode_e mode_nxt;
  fr_timer_pkg::cap_ctrl_s cap_r;
  fr_timer_pkg::cap_ctrl_s cap_nxt;
  fr_timer_pkg::out_ctrl_s outc_r;
  fr_timer_pkg::out_ctrl_s outc_nxt;
  fr_timer_pkg::os_state_e os_r;
  fr_timer_pkg::os_state_e os_nxt;
  fr_timer_pkg::evt_s evt_r;
  fr_timer_pkg::evt_s evt_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] cc_a_r;
  logic [15:0] cc_a_nxt;
  logic [15:0] cc_b_r;
  logic [15:0] cc_b_nxt;
  logic tout_r;
  logic tout_nxt;
  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic in_a_s1_r;
  logic in_a_s2_r;
  logic in_a_d_r;
  logic in_b_s1_r;
  logic in_b_s2_r;
  logic in_b_d_r;

  // ==========================================================
  // Bus decode
  wire req = i_read | i_write;
  // Write lands on the answer edge; read data latched one edge ahead
  wire wr_fire = i_write & ~wait_r;
  wire rd_take = i_read & wait_r;
  wire sel_mode = i_address == `ADDR_MODE;
  wire sel_cap = i_address == `ADDR_CAP;
  wire sel_outc = i_address == `ADDR_OUTC;
  wire sel_cnt = i_address == `ADDR_CNT;
  wire sel_cc_a = i_address == `ADDR_CC_A;
  wire sel_cc_b = i_address == `ADDR_CC_B;
  wire be_lo = i_byteenable[`LANE0];
  wire wr_mode = wr_fire & sel_mode & be_lo;
  wire wr_cap = wr_fire & sel_cap & be_lo;
  wire wr_outc = wr_fire & sel_outc & be_lo;
  wire wr_cc_a = wr_fire & sel_cc_a;
  wire wr_cc_b = wr_fire & sel_cc_b;

  // ==========================================================
  // Input edges
  wire in_a_edge_raw = edge_hit(in_a_s2_r, in_a_d_r, cap_r.edge_a);
  wire in_b_edge_raw = edge_hit(in_b_s2_r, in_b_d_r, cap_r.edge_b);

  // ==========================================================
  // Timer decode
  wire running = mode_r != fr_timer_pkg::MODE_STOP;
  wire free_mode = mode_r == fr_timer_pkg::MODE_FREE;
  wire edge_mode = mode_r == fr_timer_pkg::MODE_EDGE_CLR;
  wire match_mode = mode_r == fr_timer_pkg::MODE_MATCH_CLR;
  wire os_mode = outc_r.oneshot_enable & (free_mode | edge_mode);
  wire os_busy = os_r == fr_timer_pkg::OS_BUSY;
  wire edge_a = running & in_a_edge_raw;
  wire edge_b = running & in_b_edge_raw;
  wire sw_trig = wr_outc & i_writedata[`OS_TRIG_BIT];
  wire os_trig = os_mode & ~os_busy & (sw_trig | edge_a);
  wire cmp_a = running & ~cap_r.a_is_cap & cnt_hits(cnt_r, cc_a_r);
  wire cmp_b = running & ~cap_r.b_is_cap & cnt_hits(cnt_r, cc_b_r);
  wire cap_b = cap_r.b_is_cap & edge_a;
  wire cap_a_src = cap_r.a_src_in_a ? edge_a : edge_b;
  wire cap_a = cap_r.a_is_cap & cap_a_src;
  wire clr_edge = edge_mode & edge_a & ~os_mode;
  wire clr_match = match_mode & cmp_a;
  wire cnt_clear = ~running | os_trig | clr_edge | clr_match;
  wire cnt_wrap = ~cnt_clear & cnt_hits(cnt_r, `CNT_MAX);
  wire any_match = cmp_a | cmp_b;
  wire os_toggle = os_busy & any_match;
  wire toggle_src = os_mode ? os_toggle : any_match;
  wire toggle = outc_r.out_enable & toggle_src;
  wire ovf_clr = wr_mode & ~i_writedata[`OVF_BIT];

  // ==========================================================
  // Next values
  assign cnt_nxt = cnt_clear ? `CNT_ZERO : 16'(cnt_r + `CNT_ONE);
  assign ovf_nxt = cnt_wrap | (ovf_r & ~ovf_clr);
  assign tout_nxt = tout_r ^ toggle;
  assign evt_nxt.event_a = cmp_a | cap_a;
  assign evt_nxt.event_b = cmp_b | cap_b;
  assign cc_a_nxt = cc_next(cc_a_r, cnt_r, cap_a, wr_cc_a,
                            i_writedata, i_byteenable);
  assign cc_b_nxt = cc_next(cc_b_r, cnt_r, cap_b, wr_cc_b,
                            i_writedata, i_byteenable);
  assign mode_nxt = wr_mode ?
    fr_timer_pkg::mode_e'(i_writedata[`MODE_HI_BIT:`MODE_LO_BIT]) : mode_r;
  assign cap_nxt = wr_cap ?
    fr_timer_pkg::cap_ctrl_s'(i_writedata[$bits(fr_timer_pkg::cap_ctrl_s)-1:0]) :
    cap_r;
  assign outc_nxt = wr_outc ?
    fr_timer_pkg::out_ctrl_s'(i_writedata[$bits(fr_timer_pkg::out_ctrl_s)-1:0]) :
    outc_r;

  // ==========================================================
  // One-shot sequencer
  always_comb begin
    os_nxt = os_r;
    unique case (os_r)
      fr_timer_pkg::OS_IDLE: begin
        if (os_trig) begin
          os_nxt = fr_timer_pkg::OS_BUSY;
        end
      end
      fr_timer_pkg::OS_BUSY: begin
        if (~os_mode | cmp_b) begin
          os_nxt = fr_timer_pkg::OS_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // Read mux
  logic [15:0] mode_word;
  logic [15:0] cap_word;
  logic [15:0] outc_word;

  always_comb begin
    mode_word = `HALF_ZERO;
    mode_word[`MODE_HI_BIT:`MODE_LO_BIT] = mode_r;
    mode_word[`OVF_BIT] = ovf_r;
  end

  always_comb begin
    cap_word = `HALF_ZERO;
    cap_word[$bits(fr_timer_pkg::cap_ctrl_s)-1:0] = cap_r;
  end

  // Trigger bit reads back as zero
  always_comb begin
    outc_word = `HALF_ZERO;
    outc_word[`OS_EN_BIT:`OUT_EN_BIT] = outc_r;
    outc_word[`OS_BUSY_BIT] = os_busy;
    outc_word[`TOUT_BIT] = tout_r;
  end

  wire [31:0] rd_mux =
    sel_mode ? zext16(mode_word) :
    sel_cap ? zext16(cap_word) :
    sel_outc ? zext16(outc_word) :
    sel_cnt ? zext16(cnt_r) :
    sel_cc_a ? zext16(cc_a_r) :
    sel_cc_b ? zext16(cc_b_r) :
    `DATA_ZERO;

  assign wait_nxt = ~(req & wait_r);
  assign rdata_nxt = rd_take ? rd_mux : rdata_r;

  // ==========================================================
  // Synchronisers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      in_a_s1_r <= 1'b0;
      in_a_s2_r <= 1'b0;
      in_a_d_r <= 1'b0;
    end else begin
      in_a_s1_r <= i_timer_in_a;
      in_a_s2_r <= in_a_s1_r;
      in_a_d_r <= in_a_s2_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      in_b_s1_r <= 1'b0;
      in_b_s2_r <= 1'b0;
      in_b_d_r <= 1'b0;
    end else begin
      in_b_s1_r <= i_timer_in_b;
      in_b_s2_r <= in_b_s1_r;
      in_b_d_r <= in_b_s2_r;
    end
  end

  // ==========================================================
  // Bus registers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wait_r <= 1'b1;
      rdata_r <= `DATA_ZERO;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mode_r <= fr_timer_pkg::MODE_STOP;
      cap_r <= '0;
      outc_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      cap_r <= cap_nxt;
      outc_r <= outc_nxt;
    end
  end

  // ==========================================================
  // Counter and flag
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt_r <= `CNT_ZERO;
      ovf_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // ==========================================================
  // Capture/compare registers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cc_a_r <= `CNT_ZERO;
      cc_b_r <= `CNT_ZERO;
    end else begin
      cc_a_r <= cc_a_nxt;
      cc_b_r <= cc_b_nxt;
    end
  end

  // ==========================================================
  // Output and events
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tout_r <= 1'b0;
      evt_r <= '0;
      os_r <= fr_timer_pkg::OS_IDLE;
    end else begin
      tout_r <= tout_nxt;
      evt_r <= evt_nxt;
      os_r <= os_nxt;
    end
  end

  assign o_readdata = rdata_r;
  assign o_waitrequest = wait_r;
  assign o_timer_out = tout_r;
  assign o_event_a = evt_r.event_a;
  assign o_event_b = evt_r.event_b;

endmodule // free_run_ppg_oneshot_timer

// ---- tb/timer_chk.sv ----
module timer_chk (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_timer_out,
  input wire logic o_event_a,
  input wire logic o_event_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // ====
  // Bus answer
  a_wait_one: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("answer late");
  a_wait_pulse: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("answer too long");
  a_wait_idle: assert property (o_waitrequest && !i_read && !i_write |=> o_waitrequest)
    else $error("answer without request");
  a_wait_cause: assert property ($fell(o_waitrequest) |-> $past(i_read || i_write))
    else $error("answer not caused");
  a_rdata_hold: assert property ($changed(o_readdata) |-> !o_waitrequest)
    else $error("read data moved");
  // ====
  // Reset and outputs
  a_reset_quiet: assert property (disable iff (1'b0) i_reset |=>
    !o_timer_out && !o_event_a && !o_event_b && o_waitrequest && o_readdata == 32'h0)
    else $error("reset state wrong");
  a_post_reset: assert property ($fell(i_reset) |->
    (!o_event_a && !o_event_b && !o_timer_out) [*3])
    else $error("activity after reset");
  a_out_event: assert property ($changed(o_timer_out) |->
    ##[0:1] (o_event_a || o_event_b))
    else $error("output toggled without event");
  c_read_ans: cover property (i_read && !o_waitrequest);
  c_event_a: cover property (o_event_a);
  c_event_b: cover property (o_event_b);
  c_out_rise: cover property ($rose(o_timer_out));
endmodule // timer_chk

// ---- tb/pulse_src.sv ----
module pulse_src (
  input wire logic i_clk_sys,
  output logic o_timer_in_a,
  output logic o_timer_in_b
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_timer_in_a = 1'b0;
    o_timer_in_b = 1'b0;
  end
  // Pulse wide enough for the synchroniser
  task automatic pulse(input logic sel);
    @(posedge i_clk_sys);
    if (sel) begin
      o_timer_in_b <= 1'b1;
    end else begin
      o_timer_in_a <= 1'b1;
    end
    repeat (4) @(posedge i_clk_sys);
    o_timer_in_a <= 1'b0;
    o_timer_in_b <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
  endtask
endmodule // pulse_src

// ---- tb/testbench.sv ----
`include "fr_timer_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [4:0] addr = 5'h00;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wreq, tout, ev_a, ev_b, in_a, in_b;
  logic tout_q = 1'b0;
  int err_total = 0;
  int checks_done = 0;
  int na = 0, nb = 0, hi_w = 0, lo_w = 0, run = 0, per = 0, since = 0;
  free_run_ppg_oneshot_timer dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_address(addr), .i_read(rd_q), .i_write(wr_q), .i_writedata(wdata),
    .i_byteenable(4'hf), .o_readdata(rdata), .o_waitrequest(wreq),
    .i_timer_in_a(in_a), .i_timer_in_b(in_b), .o_timer_out(tout),
    .o_event_a(ev_a), .o_event_b(ev_b));
  pulse_src src (.i_clk_sys(i_clk_sys), .o_timer_in_a(in_a), .o_timer_in_b(in_b));
  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // ====
  // Event counts and output widths
  always @(posedge i_clk_sys) begin
    na += ev_a;
    nb += ev_b;
    run++;
    since++;
    if (tout !== tout_q) begin
      if (tout_q) hi_w = run;
      else lo_w = run;
      if (tout) begin
        per = since;
        since = 0;
      end
      run = 0;
    end
    tout_q = tout;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_clk_sys);
    addr <= a;
    wdata <= d;
    rd_q <= !w;
    wr_q <= w;
    do @(posedge i_clk_sys); while (wreq !== 1'b0);
    q = rdata;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge i_clk_sys);
    err_total++;
    conclude();
  end
  // ====
  // Tests
  initial begin
    logic [31:0] c1, c2;
    logic s;
    int a0, b0;
    repeat (4) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rd_chk(`ADDR_MODE, 32'h0);
    rd_chk(`ADDR_CNT, 32'h0);
    wr(`ADDR_MODE, 32'h1);
    rd(`ADDR_CNT, c1);
    rd(`ADDR_CNT, c2);
    check(c2 - c1, 32'h3);
    rd_chk(`ADDR_MODE, 32'h1);
    repeat (65536) @(posedge i_clk_sys);
    rd_chk(`ADDR_MODE, 32'h5);
    wr(`ADDR_MODE, 32'h1);
    rd_chk(`ADDR_MODE, 32'h1);
    wr(`ADDR_MODE, 32'h0);
    rd_chk(`ADDR_CNT, 32'h0);
    $display("test free run done");
    wr(`ADDR_CC_A, 32'h20);
    wr(`ADDR_CC_B, 32'h40);
    wr(`ADDR_OUTC, 32'h1);
    a0 = na;
    b0 = nb;
    wr(`ADDR_MODE, 32'h1);
    repeat (80) @(posedge i_clk_sys);
    check(na - a0, 32'h1);
    check(nb - b0, 32'h1);
    check(hi_w, 32'h20);
    rd(`ADDR_CNT, c1);
    check(c1 > 32'h40, 32'h1);
    $display("test compare done");
    wr(`ADDR_CAP, 32'h0a);
    b0 = nb;
    src.pulse(1'b0);
    rd(`ADDR_CC_B, c1);
    check(nb - b0, 32'h1);
    check(c1 != 32'h0, 32'h1);
    wr(`ADDR_CAP, 32'h23);
    a0 = na;
    src.pulse(1'b1);
    check(na - a0, 32'h1);
    rd_chk(`ADDR_CC_B, c1);
    rd(`ADDR_CC_A, c2);
    check(c2 != 32'h20, 32'h1);
    wr(`ADDR_CAP, 32'h0f);
    src.pulse(1'b0);
    rd(`ADDR_CC_A, c1);
    rd_chk(`ADDR_CC_B, c1);
    $display("test capture done");
    wr(`ADDR_MODE, 32'h0);
    wr(`ADDR_CAP, 32'h0);
    wr(`ADDR_CC_A, 32'h9);
    wr(`ADDR_CC_B, 32'h3);
    wr(`ADDR_MODE, 32'h3);
    repeat (60) @(posedge i_clk_sys);
    check(per, 32'ha);
    check(lo_w, 32'h4);
    check(hi_w, 32'h6);
    $display("test pulse generator done");
    wr(`ADDR_MODE, 32'h0);
    wr(`ADDR_CC_A, 32'h10);
    wr(`ADDR_CC_B, 32'h30);
    wr(`ADDR_OUTC, 32'h3);
    wr(`ADDR_MODE, 32'h1);
    s = tout;
    a0 = na;
    b0 = nb;
    wr(`ADDR_OUTC, 32'h7);
    repeat (64) @(posedge i_clk_sys);
    check(na - a0, 32'h1);
    check(nb - b0, 32'h1);
    check(s ? lo_w : hi_w, 32'h20);
    rd_chk(`ADDR_OUTC, {27'h0, s, 4'h3});
    wr(`ADDR_CAP, 32'h08);
    src.pulse(1'b0);
    repeat (64) @(posedge i_clk_sys);
    check(na - a0, 32'h2);
    check(nb - b0, 32'h2);
    $display("test one-shot done");
    wr(`ADDR_OUTC, 32'h2);
    wr(`ADDR_MODE, 32'h3);
    s = tout;
    wr(`ADDR_OUTC, 32'h6);
    rd_chk(`ADDR_OUTC, {27'h0, s, 4'h2});
    wr(`ADDR_MODE, 32'h2);
    wr(`ADDR_OUTC, 32'h6);
    rd_chk(`ADDR_OUTC, {27'h0, s, 4'ha});
    wr(`ADDR_OUTC, 32'h0);
    repeat (100) @(posedge i_clk_sys);
    rd(`ADDR_CNT, c1);
    check(c1 > 32'h40, 32'h1);
    src.pulse(1'b0);
    rd(`ADDR_CNT, c2);
    check(c2 < 32'h10, 32'h1);
    $display("test modes done");
    conclude();
  end
endmodule // testbench
bind free_run_ppg_oneshot_timer timer_chk chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .o_timer_out(o_timer_out),
  .o_event_a(o_event_a), .o_event_b(o_event_b));
